/* rtl/dac_link_device.sv */
`timescale 1ns/1ps
`include "dac_link_map.svh"
module dac_link_device
   import dac_link_pkg::*;
(
   dac_link_if.device LINK,
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic SHUTDOWN,
   input wire logic CLEAR_N,
   output logic USER_LOGIC_OUTPUT,
   output logic DOUT_MODE,
   output logic CMD_STROBE,
   output word_t CMD_WORD
);
   // link clock side
   dev_link_s lnk_ff;
   dev_link_s nxt_lnk;
   logic first_ff;
   logic dout_fall_ff;
   logic shut_lnk;
   logic frame_idle;
   dout_mode_e eff_mode;
   logic dout_pick;

   // system clock side
   dev_ctl_s ctl_ff;
   dev_ctl_s nxt_ctl;
   logic [2:0] pins_s;
   logic shut_s;
   logic clr_n_s;
   logic cs_s;
   logic cs_rise;
   logic [2:0] cmd;
   logic mode_s;

   // the held word decides the output edge for the next frame;
   // code bits 01 under the mode command leave the edge unchanged
   function automatic dout_mode_e pick_mode(input word_t w,
                                            input dout_mode_e cur);
      dout_mode_e m;
      m = cur;
      if (w[`CMD_MSB:`CMD_LSB] == `CMD_DOUT_MODE) begin
         if (w[`CODE_MSB]) begin
            m = DOUT_RISE;
         end else if (!w[`CODE_MSB-1]) begin
            m = DOUT_FALL;
         end
      end
      return m;
   endfunction

   // shutdown reaches the link side only after two link edges, so up
   // to two output bits may still move once it is raised; the serial
   // clock is the only clock there, and it stands still between frames
   dac_sync #(.W(1), .RST_VAL(1'b0)) u_shut_lnk (
      .clk(LINK.sclk),
      .rst(RESET),
      .d(SHUTDOWN),
      .q(shut_lnk)
   );

   // the serial clock stands still between frames, so a mode
   // command held in the shift register is applied at the first
   // rising edge of the next frame, before any output bit moves
   assign frame_idle = LINK.cs_n | RESET;

   // high until the first link edge of each frame
   always_ff @(posedge LINK.sclk or posedge frame_idle) begin
      if (frame_idle) begin
         first_ff <= 1'b1;
      end else begin
         first_ff <= 1'b0;
      end
   end

   always_comb begin
      nxt_lnk = lnk_ff;
      eff_mode = lnk_ff.mode;
      if (first_ff && !shut_lnk) begin
         eff_mode = pick_mode(lnk_ff.shift, lnk_ff.mode);
      end
      if (!LINK.cs_n) begin
         // din taken on the rising edge, MSB first, both bytes alike
         nxt_lnk.shift = {lnk_ff.shift[`WORD_BITS-2:0],
                          LINK.din};
         nxt_lnk.mode = eff_mode;
         if (eff_mode == DOUT_RISE && !shut_lnk) begin
            // next top bit goes out on this same rising edge
            nxt_lnk.dout_rise = lnk_ff.shift[`WORD_BITS-2];
         end
      end
   end

   always_ff @(posedge LINK.sclk or posedge RESET) begin
      if (RESET) begin
         lnk_ff <= '{shift: `WORD_RST,
                     mode: dout_mode_e'(`DOUT_MODE_RST),
                     dout_rise: 1'b0};
      end else begin
         lnk_ff <= nxt_lnk;
      end
   end

   // falling-edge copy of the top bit gives the full 16-cycle lag
   always_ff @(negedge LINK.sclk or posedge RESET) begin
      if (RESET) begin
         dout_fall_ff <= 1'b0;
      end else if (!LINK.cs_n && !shut_lnk && lnk_ff.mode == DOUT_FALL) begin
         dout_fall_ff <= lnk_ff.shift[`WORD_BITS-1];
      end
   end

   // the select flips only on a rising edge, the same edge that loads
   // the rising-edge copy, so the pin cannot glitch inside a bit;
   // both copies hold while deselected or shut down
   always_comb begin
      case (lnk_ff.mode)
         DOUT_RISE: begin
            dout_pick = lnk_ff.dout_rise;
         end
         DOUT_FALL: begin
            dout_pick = dout_fall_ff;
         end
         default: begin
            dout_pick = dout_fall_ff;
         end
      endcase
   end

   assign LINK.dout = dout_pick;

   // system clock side
   // select rise is the handshake for the held shift word: the link
   // clock stands still by then, so the word is read here unsynced
   dac_sync #(.W(3), .RST_VAL(`PIN_SYNC_RST)) u_pins (
      .clk(CLOCK),
      .rst(RESET),
      .d({SHUTDOWN, CLEAR_N, LINK.cs_n}),
      .q(pins_s)
   );

   assign shut_s = pins_s[2];
   assign clr_n_s = pins_s[1];
   assign cs_s = pins_s[0];

   always_comb begin
      nxt_ctl = ctl_ff;
      nxt_ctl.cs_prev = cs_s;
      nxt_ctl.strobe = 1'b0;
      // the shift register is quiet once select is high, so it
      // can be read here after the select edge has been synced
      cs_rise = cs_s && !ctl_ff.cs_prev;
      cmd = lnk_ff.shift[`CMD_MSB:`CMD_LSB];
      if (cs_rise) begin
         nxt_ctl.word = lnk_ff.shift;
         nxt_ctl.strobe = 1'b1;
      end
      // commands for the logic output are dropped, not queued, while
      // shut down; a clear outranks a command in the same cycle
      if (shut_s) begin
         // level held; a clear seen now takes effect at wake-up
         if (!clr_n_s) begin
            nxt_ctl.clr_pend = 1'b1;
         end
      end else if (ctl_ff.clr_pend || !clr_n_s) begin
         nxt_ctl.upo = `UPO_RST;
         nxt_ctl.clr_pend = 1'b0;
      end else if (cs_rise) begin
         case (cmd)
            `CMD_UPO_LOW: begin
               nxt_ctl.upo = 1'b0;
            end
            `CMD_UPO_HIGH: begin
               nxt_ctl.upo = 1'b1;
            end
            default: begin
               nxt_ctl.upo = ctl_ff.upo;
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         ctl_ff <= '{cs_prev: `CS_IDLE_RST,
                     clr_pend: 1'b0,
                     upo: `UPO_RST,
                     strobe: 1'b0,
                     word: `WORD_RST};
      end else begin
         ctl_ff <= nxt_ctl;
      end
   end

   // the mode lives on the link clock; bring it over before it leaves
   // the block, as everything else here is read on the system clock;
   // it only moves at a frame's first edge, so one bit is safe to sync
   dac_sync #(.W(1), .RST_VAL(`DOUT_MODE_RST)) u_mode_sync (
      .clk(CLOCK),
      .rst(RESET),
      .d(lnk_ff.mode),
      .q(mode_s)
   );

   assign USER_LOGIC_OUTPUT = ctl_ff.upo;
   assign CMD_STROBE = ctl_ff.strobe;
   assign CMD_WORD = ctl_ff.word;
   assign DOUT_MODE = mode_s;
endmodule

/* rtl/dac_link_host.sv */
`timescale 1ns/1ps
`include "dac_link_map.svh"
module dac_link_host
   import dac_link_pkg::*;
(
   dac_link_if.host LINK,
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic START,
   input wire word_t TX_WORD,
   input wire logic SAMPLE_ON_FALL,
   output logic BUSY,
   output word_t RX_WORD,
   output logic RX_VALID
);
   localparam logic [3:0] HALF_LAST = 4'(`SCLK_HALF_CYC - 1);
   localparam logic [3:0] SAMPLE_AT = 4'(`SYNC_LAT_CYC);
   localparam logic [3:0] LAST_BIT = 4'(`WORD_BITS - 1);

   host_s h_ff;
   host_s nxt_h;
   logic dout_s;
   logic tick;
   logic take;

   dac_sync #(.W(1), .RST_VAL(1'b0)) u_dout_sync (
      .clk(CLOCK),
      .rst(RESET),
      .d(LINK.dout),
      .q(dout_s)
   );

   always_comb begin
      nxt_h = h_ff;
      nxt_h.rx_valid = 1'b0;
      tick = (h_ff.cnt == HALF_LAST);
      nxt_h.cnt = tick ? 4'h0 : h_ff.cnt + 4'h1;
      // sample point sits mid-bit, after the two-stage delay
      take = (h_ff.cnt == SAMPLE_AT);
      case (h_ff.state)
         H_IDLE: begin
            nxt_h.cnt = 4'h0;
            if (START) begin
               // sub_bit forced to zero whatever the user passes
               nxt_h.tx = {TX_WORD[`CMD_MSB:`CODE_LSB], `SUB_VAL};
               nxt_h.din = TX_WORD[`CMD_MSB];
               nxt_h.cs_n = 1'b0;
               nxt_h.busy = 1'b1;
               nxt_h.bitn = 4'h0;
               nxt_h.state = H_SETUP;
            end
         end
         H_SETUP: begin
            if (tick) begin
               nxt_h.sclk = 1'b1;
               nxt_h.state = H_HIGH;
            end
         end
         H_HIGH: begin
            if (take && !SAMPLE_ON_FALL) begin
               nxt_h.rx = {h_ff.rx[`WORD_BITS-2:0], dout_s};
            end
            if (tick) begin
               nxt_h.sclk = 1'b0;
               if (h_ff.bitn == LAST_BIT) begin
                  nxt_h.state = H_HOLD;
               end else begin
                  // both bytes go out with no pause between them
                  nxt_h.bitn = h_ff.bitn + 4'h1;
                  nxt_h.tx = {h_ff.tx[`WORD_BITS-2:0], 1'b0};
                  nxt_h.din = h_ff.tx[`WORD_BITS-2];
                  nxt_h.state = H_LOW;
               end
            end
         end
         H_LOW: begin
            if (take && SAMPLE_ON_FALL) begin
               nxt_h.rx = {h_ff.rx[`WORD_BITS-2:0], dout_s};
            end
            if (tick) begin
               nxt_h.sclk = 1'b1;
               nxt_h.state = H_HIGH;
            end
         end
         H_HOLD: begin
            if (take && SAMPLE_ON_FALL) begin
               nxt_h.rx = {h_ff.rx[`WORD_BITS-2:0], dout_s};
            end
            if (tick) begin
               nxt_h.cs_n = 1'b1;
               nxt_h.rx_word = h_ff.rx;
               nxt_h.rx_valid = 1'b1;
               nxt_h.state = H_GAP;
            end
         end
         H_GAP: begin
            // deselect time lets the device see the select edge
            if (tick) begin
               nxt_h.busy = 1'b0;
               nxt_h.state = H_IDLE;
            end
         end
         default: begin
            nxt_h.state = H_IDLE;
            nxt_h.cs_n = 1'b1;
            nxt_h.sclk = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         h_ff <= '{state: H_IDLE, cnt: 4'h0, bitn: 4'h0, tx: 16'h0000,
                   rx: 16'h0000, sclk: 1'b0, cs_n: 1'b1, din: 1'b0,
                   busy: 1'b0, rx_valid: 1'b0, rx_word: 16'h0000};
      end else begin
         h_ff <= nxt_h;
      end
   end

   assign LINK.sclk = h_ff.sclk;
   assign LINK.cs_n = h_ff.cs_n;
   assign LINK.din = h_ff.din;
   assign BUSY = h_ff.busy;
   assign RX_WORD = h_ff.rx_word;
   assign RX_VALID = h_ff.rx_valid;
endmodule

/* rtl/dac_link_if.sv */
`timescale 1ns/1ps
interface dac_link_if;
   logic sclk;
   logic cs_n;
   logic din;
   logic dout;

   modport device (
      input sclk,
      input cs_n,
      input din,
      output dout
   );

   modport host (
      output sclk,
      output cs_n,
      output din,
      input dout
   );
endinterface

/* rtl/dac_link_map.svh */
`ifndef DAC_LINK_MAP_SVH
`define DAC_LINK_MAP_SVH
// Notes on behaviour
// - host sends word as two back-to-back bytes
// - first byte: command bits, code_bits top five
// - second byte: seven low code bits, sub_bit
// - host changes data falling, device samples rising
// - device shifts register contents out serially
// - output edge follows selected output mode
// - falling mode after reset, lag sixteen cycles
// - rising mode lag is fifteen and half cycles
// - serial output frozen while shut down
// - logic output set only by serial commands
// - logic output holds its level during shutdown
// - clear held low returns output low on wake
// - host is master, clock idles low
// - host samples returned data mid-bit
// - sixteen bits MSB first, sub_bit zero
// - shift only with select low, decode on rise
// - command 100 drives low, 110 drives high
// - command 111 selects rising or falling mode

`define WORD_BITS 16
`define CMD_MSB 15
`define CMD_LSB 13
`define CODE_MSB 12
`define CODE_LSB 1
`define SUB_POS 0
`define CMD_UPO_LOW 3'h4
`define CMD_UPO_HIGH 3'h6
`define CMD_DOUT_MODE 3'h7
`define SUB_VAL 1'h0
`define UPO_RST 1'h0
`define DOUT_MODE_RST 1'h0
`define CS_IDLE_RST 1'h1
`define WORD_RST 16'h0000
`define PIN_SYNC_RST 3'h3
`define CLK_PERIOD_NS 40
`define SCLK_HALF_NS 160
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_LAT_CYC 2
`endif

/* rtl/dac_link_pkg.sv */
package dac_link_pkg;
   typedef logic [15:0] word_t;

   typedef enum logic {
      DOUT_FALL = 1'b0,
      DOUT_RISE = 1'b1
   } dout_mode_e;

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_SETUP = 3'b001,
      H_HIGH = 3'b010,
      H_LOW = 3'b011,
      H_HOLD = 3'b100,
      H_GAP = 3'b101
   } host_state_e;

   typedef struct packed {
      word_t shift;
      dout_mode_e mode;
      logic dout_rise;
   } dev_link_s;

   typedef struct packed {
      logic cs_prev;
      logic clr_pend;
      logic upo;
      logic strobe;
      word_t word;
   } dev_ctl_s;

   typedef struct packed {
      host_state_e state;
      logic [3:0] cnt;
      logic [3:0] bitn;
      word_t tx;
      word_t rx;
      logic sclk;
      logic cs_n;
      logic din;
      logic busy;
      logic rx_valid;
      word_t rx_word;
   } host_s;
endpackage

/* rtl/dac_sync.sv */
`timescale 1ns/1ps
module dac_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_s;

   sync_s sync_ff;
   sync_s nxt_sync;

   // first stage feeds the second stage only
   always_comb begin
      nxt_sync.s1 = d;
      nxt_sync.s2 = sync_ff.s1;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync_ff <= {RST_VAL, RST_VAL};
      end else begin
         sync_ff <= nxt_sync;
      end
   end

   assign q = sync_ff.s2;
endmodule

/* verif/dac_link_props.sv */
`timescale 1ns/1ps
module dac_link_props (
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic dout
);
   logic sclk_q;
   logic [4:0] edges;

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RESET);

   // link clock is far slower than the system clock, so edges are seen here
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         sclk_q <= 1'b0;
         edges <= 5'h00;
      end else begin
         sclk_q <= sclk;
         edges <= cs_n ? 5'h00 : edges + 5'(sclk & ~sclk_q);
      end
   end

   AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
      else $error("link clock runs while deselected");
   AST_DIN_HOLD: assert property (sclk |-> $stable(din))
      else $error("data in moved while link clock high");
   AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
      else $error("link clock high phase not four cycles");
   AST_FIRST_EDGE: assert property ($fell(cs_n) |-> !sclk [*4] ##1 sclk)
      else $error("first link edge misplaced after select");
   AST_EDGE_COUNT: assert property ($rose(cs_n) |-> edges == 5'h10)
      else $error("frame did not hold sixteen edges");
   AST_DOUT_QUIET: assert property (cs_n && $past(cs_n) |-> $stable(dout))
      else $error("data out moved while deselected");
   AST_DOUT_AT_EDGE: assert property ($changed(dout) |-> $changed(sclk))
      else $error("data out moved off a link edge");
   AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n [*3])
      else $error("select high gap too short");

   cover property ($rose(cs_n));
   cover property ($changed(dout) && $rose(sclk));
   cover property ($changed(dout) && $fell(sclk));
endmodule

/* verif/dac_serial_port_readback_upo_bench.sv */
`timescale 1ns/1ps
module dac_serial_port_readback_upo_bench
   import dac_link_pkg::*;
;
   logic clock, reset, start, sample_on_fall, shutdown, clear_n;
   logic busy, rx_valid, user_out, dout_mode, cmd_strobe, dsave;
   word_t tx_word, rx_word, cmd_word, wire_q, rx;
   int bad_count = 0;
   int num_checks = 0;

   dac_link_if link();
   dac_link_host u_dac_link_host (.LINK(link), .CLOCK(clock), .RESET(reset),
      .START(start), .TX_WORD(tx_word), .SAMPLE_ON_FALL(sample_on_fall),
      .BUSY(busy), .RX_WORD(rx_word), .RX_VALID(rx_valid));
   dac_link_device u_dac_link_device (.LINK(link), .CLOCK(clock),
      .RESET(reset), .SHUTDOWN(shutdown), .CLEAR_N(clear_n),
      .USER_LOGIC_OUTPUT(user_out), .DOUT_MODE(dout_mode),
      .CMD_STROBE(cmd_strobe), .CMD_WORD(cmd_word));
   dac_link_props u_dac_link_props (.CLOCK(clock), .RESET(reset),
      .sclk(link.sclk), .cs_n(link.cs_n), .din(link.din), .dout(link.dout));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // bits as the device samples them, independent of the host's view
   always @(posedge link.sclk) begin
      if (link.cs_n === 1'b0) wire_q <= {wire_q[14:0], link.din};
   end

   task automatic chk(input string n, input word_t e, input word_t g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask

   task automatic wait_for(input int which, input int lim);
      int n;
      n = 0;
      while (!((which == 0 && rx_valid === 1'b1) ||
               (which == 1 && cmd_strobe === 1'b1) ||
               (which == 2 && busy === 1'b0))) begin
         tick(1);
         n++;
         if (n > lim) begin
            bad_count++;
            $display("BAD wait %0d expected done seen stuck", which);
            finish_test();
         end
      end
   endtask

   // one whole frame; sub_bit always leaves as zero
   task automatic xfer(input word_t w);
      start = 1'b1;
      tx_word = w;
      tick(1);
      start = 1'b0;
      wait_for(0, 300);
      rx = rx_word;
      wait_for(1, 10);
      chk("cmd_word", w & 16'hFFFE, cmd_word);
      chk("wire", w & 16'hFFFE, wire_q);
      wait_for(2, 20);
   endtask

   task automatic t_reset();
      chk("mode", 16'h0000, 16'(dout_mode));
      chk("user_out", 16'h0000, 16'(user_out));
      $display("reset values done");
   endtask

   task automatic t_readback();
      sample_on_fall = 1'b0;
      xfer(16'h3579);
      xfer(16'h2C42);
      chk("readback", 16'h3578, rx);
      xfer(16'h0000);
      chk("readback", 16'h2C42, rx);
      $display("falling readback done");
   endtask

   task automatic t_user_out();
      word_t cw [5] = '{16'hC000, 16'h8000, 16'hDFFE, 16'h2000, 16'h9FFE};
      logic ue [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
      for (int i = 0; i < 5; i++) begin
         xfer(cw[i]);
         chk("user_out", 16'(ue[i]), 16'(user_out));
      end
      $display("user output commands done");
   endtask

   task automatic t_mode();
      xfer(16'hF000);
      chk("mode", 16'h0000, 16'(dout_mode));
      xfer(16'hA5A4);
      chk("mode", 16'h0001, 16'(dout_mode));
      sample_on_fall = 1'b1;
      xfer(16'h0002);
      chk("readback", 16'h4B48, rx);
      // code bits 01 are not a mode request
      xfer(16'hE800);
      xfer(16'h0000);
      chk("mode", 16'h0001, 16'(dout_mode));
      xfer(16'hE000);
      xfer(16'h0000);
      chk("mode", 16'h0000, 16'(dout_mode));
      sample_on_fall = 1'b0;
      xfer(16'h1110);
      xfer(16'h0000);
      chk("readback", 16'h1110, rx);
      $display("output mode done");
   endtask

   task automatic t_shutdown();
      xfer(16'hC000);
      shutdown = 1'b1;
      tick(4);
      // link side sees shutdown only after two link edges, so skip a frame
      xfer(16'h5FFE);
      dsave = link.dout;
      xfer(16'h8000);
      chk("dout", 16'(dsave), 16'(link.dout));
      chk("user_out", 16'h0001, 16'(user_out));
      xfer(16'h0000);
      chk("dout", 16'(dsave), 16'(link.dout));
      clear_n = 1'b0;
      tick(6);
      chk("user_out", 16'h0001, 16'(user_out));
      clear_n = 1'b1;
      tick(2);
      shutdown = 1'b0;
      tick(8);
      chk("user_out", 16'h0000, 16'(user_out));
      $display("shutdown done");
   endtask

   initial begin
      reset = 1'b1;
      start = 1'b0;
      tx_word = 16'h0000;
      sample_on_fall = 1'b0;
      shutdown = 1'b0;
      clear_n = 1'b1;
      tick(6);
      reset = 1'b0;
      tick(2);
      t_reset();
      t_readback();
      t_user_out();
      t_mode();
      t_shutdown();
      finish_test();
   end
endmodule
